// file: hdl/dpram_host_pkg.sv
// Package of constants and types for the dual-port SRAM host controller.
package dpram_host_pkg;

  // ----------------------------------------------------------------
  // Geometry of the attached memory.
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 12;   // 4K words.
  localparam int DATA_W     = 8;    // Eight-bit words.
  localparam int FLAG_SEL_W = 3;    // Eight semaphore latches.

  // ----------------------------------------------------------------
  // Timing of the attached memory, in nanoseconds, and in cycles.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS            = 100;
  localparam int ACCESS_TIME_NS           = 15;  // Select to data valid.
  localparam int ENABLE_TO_DATA_NS        = 10;  // Output enable to data valid.
  localparam int WRITE_PULSE_MIN_NS       = 12;
  localparam int WRITE_TO_OUTPUT_OFF_NS   = 10;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 10;
  localparam int FLAG_UPDATE_PULSE_MIN_NS = 10;
  localparam int FLAG_WRITE_TO_READ_MIN_NS = 5;

  // Least times round up to whole cycles, never below one.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_CYC = ns_to_cycles((ACCESS_TIME_NS > ENABLE_TO_DATA_NS) ?
                                         ACCESS_TIME_NS : ENABLE_TO_DATA_NS);
  localparam int WRITE_CYC = ns_to_cycles(
    (WRITE_PULSE_MIN_NS > WRITE_TO_OUTPUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS) ?
    WRITE_PULSE_MIN_NS : WRITE_TO_OUTPUT_OFF_NS + DATA_SETUP_TO_WRITE_END_NS);
  localparam int GAP_CYC = ns_to_cycles(
    (FLAG_UPDATE_PULSE_MIN_NS > FLAG_WRITE_TO_READ_MIN_NS) ?
    FLAG_UPDATE_PULSE_MIN_NS : FLAG_WRITE_TO_READ_MIN_NS);

  localparam logic [3:0] CNT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_GAP   = 3'b100
  } seq_t;

endpackage : dpram_host_pkg

// file: hdl/cycle_timer.sv
// Down-counter that paces each phase of one pin access.
`timescale 1ns/1ns
module cycle_timer
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       load,   // Start a new count.
  input  wire logic [3:0] value,  // Cycles to count.
  output logic            done    // High once the count has run out.
);

  logic [3:0] count;  // Cycles left in this phase.

  // ----------------------------------------------------------------
  // Counter.
  // ----------------------------------------------------------------
  // Loading takes priority so that back to back phases never overlap.
  always_ff @(posedge clk)
  begin
    if (srst)
      count <= 4'h0;
    else if (ce)
    begin
      if (load)
        count <= value;
      else if (count != 4'h0)
        count <= count - 4'h1;
    end
  end

  assign done = (count == 4'h0);

endmodule // cycle_timer

// file: hdl/dpram_host.sv
// Host controller driving one port of an asynchronous dual-port SRAM.
//
// What this block does
// - Write line high while address changes.
// - Write pulse covers turn-off plus setup.
// - Masters avoid same location simultaneously; left to the user, no arbitration here.
// - Drive data only after outputs off.
// - Read asserts select and enable, waits.
// - Semaphore access uses semaphore select instead.
// - Deassert after flag write before read.
// - Low three address bits pick latch.
// - Write zero requests, read zero owns.
// - Never both selects low together.
`timescale 1ns/1ns
module dpram_host
  import dpram_host_pkg::*;
(
  input  wire logic                                 CLOCK,
  input  wire logic                                 SRST,
  input  wire logic                                 CLK_EN,
  input  wire logic                                 REQ_VALID,   // User request pulse.
  input  wire logic                                 REQ_WRITE,   // 1 write, 0 read.
  input  wire logic                                 REQ_FLAG,    // 1 semaphore, 0 memory.
  input  wire logic [dpram_host_pkg::ADDR_W-1:0]    REQ_ADDR,
  input  wire logic [dpram_host_pkg::DATA_W-1:0]    REQ_WDATA,
  output logic                                      REQ_READY,
  output logic                                      RSP_VALID,   // One-cycle pulse.
  output logic [dpram_host_pkg::DATA_W-1:0]         RSP_RDATA,
  output logic                                      CHIP_SELECT_N,
  output logic                                      SEMAPHORE_SELECT_N,
  output logic                                      OUTPUT_ENABLE_N,
  output logic                                      READ_WRITE_N,
  output logic [dpram_host_pkg::ADDR_W-1:0]         MEM_ADDR,
  output logic [dpram_host_pkg::DATA_W-1:0]         DATA_OUT,
  output logic                                      DATA_OE,
  input  wire logic [dpram_host_pkg::DATA_W-1:0]    DATA_IN
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  seq_t                 state;       // Sequencer state.
  seq_t                 next_state;  // Sequencer next state.
  logic                 is_write;    // Latched request kind.
  logic                 is_flag;     // Latched semaphore access.
  logic [DATA_W-1:0]    din_meta;    // First synchroniser stage.
  logic [DATA_W-1:0]    din_sync;    // Second synchroniser stage.
  logic                 timer_load;  // Starts a phase count.
  logic [3:0]           timer_value; // Length of that phase.
  logic                 timer_done;  // Phase has run its length.
  logic                 take;        // Request accepted this cycle.

  assign take = REQ_VALID && REQ_READY;

  // Phase timer; the sequencer only advances when its phase is done.
  cycle_timer u_timer
  (
    .clk   (CLOCK),
    .srst  (SRST),
    .ce    (CLK_EN),
    .load  (timer_load),
    .value (timer_value),
    .done  (timer_done)
  );

  // ----------------------------------------------------------------
  // Data pin synchroniser.
  // ----------------------------------------------------------------
  // The pins are asynchronous to CLOCK, so two stages guard the capture.
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end
    else if (CLK_EN)
    begin
      din_meta <= DATA_IN;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state.
  // ----------------------------------------------------------------
  // The read phase is two cycles longer than the access time to cover
  // the two synchroniser stages.
  always_comb
  begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = 4'h0;
    unique case (state)
      ST_IDLE:
      begin
        if (take)
        begin
          next_state  = ST_SETUP;
          timer_load  = 1'b1;
          timer_value = CNT_ONE;
        end
      end
      ST_SETUP:
      begin
        // Address has settled with the write line high.
        if (timer_done)
        begin
          next_state  = is_write ? ST_WRITE : ST_READ;
          timer_load  = 1'b1;
          timer_value = is_write ? 4'(WRITE_CYC) : 4'(READ_CYC + 2);
        end
      end
      ST_READ, ST_WRITE:
      begin
        if (timer_done)
        begin
          next_state  = ST_GAP;
          timer_load  = 1'b1;
          timer_value = 4'(GAP_CYC);
        end
      end
      ST_GAP:
      begin
        if (timer_done)
          next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer state register.
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      state <= ST_IDLE;
    else if (CLK_EN)
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Request capture.
  // ----------------------------------------------------------------
  // Address and data are latched once so they cannot move mid access.
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      is_write <= 1'b0;
      is_flag  <= 1'b0;
      MEM_ADDR <= 12'h000;
      DATA_OUT <= 8'h00;
    end
    else if (CLK_EN && take)
    begin
      is_write <= REQ_WRITE;
      is_flag  <= REQ_FLAG;
      // Semaphores only look at the low three bits; upper ones cleared.
      MEM_ADDR <= REQ_FLAG ? {9'h000, REQ_ADDR[FLAG_SEL_W-1:0]} : REQ_ADDR;
      // Only bit zero counts for a flag: zero requests, one releases.
      DATA_OUT <= REQ_FLAG ? {7'h00, REQ_WDATA[0]} : REQ_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive.
  // ----------------------------------------------------------------
  // Address changes only in IDLE, where the write line is already high.
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      CHIP_SELECT_N      <= 1'b1;
      SEMAPHORE_SELECT_N <= 1'b1;
      OUTPUT_ENABLE_N    <= 1'b1;
      READ_WRITE_N       <= 1'b1;
      DATA_OE            <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // At most one select at a time; memory or semaphore.
      CHIP_SELECT_N      <= !((next_state == ST_READ || next_state == ST_WRITE) && !is_flag);
      SEMAPHORE_SELECT_N <= !((next_state == ST_READ || next_state == ST_WRITE) && is_flag);
      // Read holds enable low for the whole access; released in GAP.
      OUTPUT_ENABLE_N    <= !(next_state == ST_READ);
      // Write line low only inside WRITE, never across an address move.
      READ_WRITE_N       <= !(next_state == ST_WRITE);
      // Output enable is high during writes, so the device is already off.
      DATA_OE            <= (next_state == ST_WRITE);
    end
  end

  // ----------------------------------------------------------------
  // Response path.
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 8'h00;
      REQ_READY <= 1'b0;
    end
    else if (CLK_EN)
    begin
      RSP_VALID <= (state == ST_READ || state == ST_WRITE) && timer_done;
      // Sample the synchronised pins at the end of the read phase.
      if (state == ST_READ && timer_done)
        RSP_RDATA <= din_sync;
      REQ_READY <= (next_state == ST_IDLE) && !take;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence write_low_s;
    !READ_WRITE_N;
  endsequence

  both_selects_a: assert property (@(posedge CLOCK) disable iff (SRST)
    CHIP_SELECT_N || SEMAPHORE_SELECT_N)
    else $error("Both selects low together.");

  addr_stable_a: assert property (@(posedge CLOCK) disable iff (SRST)
    $changed(MEM_ADDR) |-> READ_WRITE_N)
    else $error("Address moved with write line low.");

  write_drive_a: assert property (@(posedge CLOCK) disable iff (SRST)
    DATA_OE |-> OUTPUT_ENABLE_N && !READ_WRITE_N)
    else $error("Data driven while device may drive.");

  write_pulse_a: assert property (@(posedge CLOCK) disable iff (SRST)
    $fell(READ_WRITE_N) && CLK_EN |=> write_low_s)
    else $error("Write pulse too short.");

  read_enable_a: assert property (@(posedge CLOCK) disable iff (SRST)
    !OUTPUT_ENABLE_N |-> READ_WRITE_N && !(CHIP_SELECT_N && SEMAPHORE_SELECT_N))
    else $error("Read enable without select.");

  flag_gap_a: assert property (@(posedge CLOCK) disable iff (SRST)
    $rose(SEMAPHORE_SELECT_N) |=> SEMAPHORE_SELECT_N)
    else $error("Flag update pulse too short.");

  flag_addr_a: assert property (@(posedge CLOCK) disable iff (SRST)
    !SEMAPHORE_SELECT_N |-> MEM_ADDR[ADDR_W-1:FLAG_SEL_W] == 9'h000)
    else $error("Semaphore address upper bits set.");

  rsp_pulse_a: assert property (@(posedge CLOCK) disable iff (SRST)
    RSP_VALID && CLK_EN |=> !RSP_VALID)
    else $error("Response held more than one cycle.");

endmodule // dpram_host

// file: sim/dpram_model.sv
// Behavioural model of one port of the semaphored dual-port SRAM.
`timescale 1ns/1ns
module dpram_model
(
  input  wire logic        cs_n,        // Memory select, active low.
  input  wire logic        sem_n,       // Semaphore select, active low.
  input  wire logic        oe_n,        // Output enable, active low.
  input  wire logic        rw_n,        // Low means write.
  input  wire logic        clk,         // Samples write capture and checks.
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  dout,        // Data from the host.
  input  wire logic        doe,         // Host drives the data pins.
  input  wire logic [7:0]  other_hold,  // Latches owned by the far port.
  output logic      [7:0]  din,
  output int               viol         // Count of host misbehaviour.
);
  logic [7:0]  mem [0:4095];
  logic [7:0]  mine;          // Latches this port owns.
  logic [7:0]  last;          // Last driven value, inverted once released.
  logic [11:0] wa;
  logic [7:0]  wd;
  logic        ws;
  logic        drv;
  logic [7:0]  rd;
  wire         wr_act = (~cs_n | ~sem_n) & ~rw_n;

  initial
  begin
    viol = 0;
    mine = 8'h00;
    last = 8'h00;
  end

  // ----------------------------------------------------------------
  // Read path: select and enable both low, data after the later delay.
  // ----------------------------------------------------------------
  assign drv = ~oe_n & rw_n & (~cs_n | ~sem_n);
  assign rd  = ~sem_n ? {8{~mine[addr[2:0]]}} : mem[addr];
  always @*
    if (drv)
      last = rd;
  // No pull-up on the data lines, so a released bus shows a changed value.
  assign #15 din = drv ? rd : ~last;

  // ----------------------------------------------------------------
  // Write capture: sample mid-cycle, commit when the write ends.
  // ----------------------------------------------------------------
  always @(negedge clk)
  begin
    if (wr_act)
    begin
      wa <= addr;
      wd <= dout;
      ws <= ~sem_n;
      if (!doe)
        viol <= viol + 1;
    end
    if (doe && drv)
      viol <= viol + 1;
    if (!cs_n && !sem_n)
      viol <= viol + 1;
  end

  always @(negedge wr_act)
    if (ws)
      mine[wa[2:0]] <= ~wd[0] & ~other_hold[wa[2:0]];
    else
      mem[wa] <= wd;

  // The address must never move while a write is open.
  always @(addr)
    #1 if (!rw_n && (!cs_n || !sem_n))
      viol = viol + 1;
endmodule // dpram_model

// file: sim/dpram_host_tb.sv
// Self-checking testbench for the dual-port SRAM host controller.
`timescale 1ns/1ns
module dpram_host_tb;
  import dpram_host_pkg::*;
  logic clk, srst, clk_en, rv, rwr, rfl, rdy, rspv, cs_n, sem_n, oe_n, rw_n, doe;
  logic [11:0] ra, ma;
  logic [7:0]  wd, rq, dout, din, hold, q;
  int          mismatches, tests_run, viol;

  dpram_host i_dut (.CLOCK(clk), .SRST(srst), .CLK_EN(clk_en), .REQ_VALID(rv),
    .REQ_WRITE(rwr), .REQ_FLAG(rfl), .REQ_ADDR(ra), .REQ_WDATA(wd), .REQ_READY(rdy),
    .RSP_VALID(rspv), .RSP_RDATA(rq), .CHIP_SELECT_N(cs_n), .SEMAPHORE_SELECT_N(sem_n),
    .OUTPUT_ENABLE_N(oe_n), .READ_WRITE_N(rw_n), .MEM_ADDR(ma), .DATA_OUT(dout),
    .DATA_OE(doe), .DATA_IN(din));
  dpram_model i_mem (.cs_n(cs_n), .sem_n(sem_n), .oe_n(oe_n), .rw_n(rw_n), .clk(clk),
    .addr(ma), .dout(dout), .doe(doe), .other_hold(hold), .din(din), .viol(viol));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers.
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  // One request, held until taken, then a bounded wait for the answer.
  task automatic access(input logic w, input logic f, input logic [11:0] a,
                        input logic [7:0] d);
    int n;
    @(negedge clk);
    rv = 1'b1; rwr = w; rfl = f; ra = a; wd = d;
    n = 0;
    // Ready seen at a falling edge means the next rising edge takes the request.
    while (!(rdy === 1'b1 && clk_en === 1'b1) && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rv = 1'b0;
    check("ready drop", 8'h00, {7'h00, rdy});
    n = 0;
    while (rspv !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    check("response", 8'h01, {7'h00, rspv});
    q = rq;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset_pins();
    check("idle pins", 8'h0F, {4'h0, cs_n, sem_n, oe_n, rw_n});
    check("idle drive", 8'h00, {6'h00, doe, rspv});
  endtask

  // Back-to-back accesses at both ends of the array.
  task automatic t_memory();
    access(1'b1, 1'b0, 12'h000, 8'hA5);
    access(1'b1, 1'b0, 12'hFFF, 8'h5A);
    access(1'b0, 1'b0, 12'h000, 8'h00);
    check("mem low", 8'hA5, q);
    access(1'b0, 1'b0, 12'hFFF, 8'h00);
    check("mem high", 8'h5A, q);
  endtask

  // Request, deny, release; upper address bits and data bits must not matter.
  task automatic t_flags();
    // A known word in memory at the latch's address must survive the flag traffic.
    access(1'b1, 1'b0, 12'h005, 8'h77);
    access(1'b1, 1'b1, 12'hFF5, 8'hFE);
    access(1'b0, 1'b1, 12'h005, 8'h00);
    check("flag owned", 8'h00, q);
    access(1'b1, 1'b1, 12'h002, 8'h00);
    access(1'b0, 1'b1, 12'h802, 8'h00);
    check("flag denied", 8'hFF, q);
    access(1'b1, 1'b1, 12'h005, 8'h01);
    access(1'b0, 1'b1, 12'h005, 8'h00);
    check("flag freed", 8'hFF, q);
    access(1'b0, 1'b0, 12'h005, 8'h00);
    check("mem apart", 8'h77, q);
  endtask

  // A stall of the clock enable mid-access must not corrupt the transfer.
  task automatic t_freeze();
    fork
      access(1'b1, 1'b0, 12'h123, 8'h3C);
      begin
        repeat (3) @(negedge clk);
        clk_en = 1'b0;
        repeat (5) @(negedge clk);
        clk_en = 1'b1;
      end
    join
    access(1'b0, 1'b0, 12'h123, 8'h00);
    check("frozen write", 8'h3C, q);
  endtask

  // Reset in mid-read must drop every select at once.
  task automatic t_midreset();
    @(negedge clk);
    rv = 1'b1; rwr = 1'b0; rfl = 1'b0; ra = 12'h123;
    repeat (3) @(negedge clk);
    rv = 1'b0;
    @(negedge clk);
    // The read must really be under way when reset strikes.
    check("mid read", 8'h00, {7'h00, cs_n});
    srst = 1'b1;
    @(negedge clk);
    // One reset edge is enough to release every pin.
    t_reset_pins();
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_reset_pins();
    repeat (2) @(negedge clk);
    access(1'b0, 1'b0, 12'h123, 8'h00);
    check("after reset", 8'h3C, q);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    mismatches = 0; tests_run = 0; srst = 1'b1; clk_en = 1'b1; rv = 1'b0;
    rwr = 1'b0; rfl = 1'b0; ra = 12'h000; wd = 8'h00; hold = 8'h04;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_reset_pins();
    repeat (2) @(negedge clk);
    t_memory();
    t_flags();
    t_freeze();
    t_midreset();
    check("pin misuse", 8'h00, viol[7:0]);
    stop_test();
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial
  begin
    #(5000 * 100);
    mismatches++;
    stop_test();
  end
endmodule // dpram_host_tb
